/* hw/rtis_pkg.sv */
/*
  Constants and carrier types for the interrupt, status and seconds logic
  of the real-time clock.
  Assumes the serial bus engine hands over decoded byte accesses on the
  system clock, and that the oscillator domain runs at 32.768 kHz.
*/
package rtis_pkg;

  // register offsets
  localparam logic [7:0] ADDR_CTRL     = 8'h01;
  localparam logic [7:0] ADDR_SECS     = 8'h02;

  // control and status field positions
  localparam int         BIT_TIE       = 0;
  localparam int         BIT_AIE       = 1;
  localparam int         BIT_TF        = 2;
  localparam int         BIT_AF        = 3;
  localparam int         BIT_MODE      = 4;

  // seconds register field positions
  localparam int         BIT_VL        = 7;
  localparam int         TENS_MSB      = 6;
  localparam int         TENS_LSB      = 4;
  localparam int         UNITS_MSB     = 3;

  // reset values
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam logic [6:0] SECS_RESET    = 7'h00;
  localparam logic       VL_RESET      = 1'b1;

  // timer source clock selection
  localparam logic [1:0] SRC_4096HZ    = 2'h0;
  localparam logic [1:0] SRC_64HZ      = 2'h1;
  localparam logic [1:0] SRC_1HZ       = 2'h2;
  localparam logic [1:0] SRC_1_60HZ    = 2'h3;

  // oscillator rate and interrupt pulse widths, given as 1/x seconds
  localparam int         OSC_HZ        = 32768;
  localparam int         PW_8192_DEN   = 8192;
  localparam int         PW_4096_DEN   = 4096;
  localparam int         PW_128_DEN    = 128;
  localparam int         PW_64_DEN     = 64;
  localparam logic [9:0] PW_8192_CYC   = 10'(OSC_HZ / PW_8192_DEN);
  localparam logic [9:0] PW_4096_CYC   = 10'(OSC_HZ / PW_4096_DEN);
  localparam logic [9:0] PW_128_CYC    = 10'(OSC_HZ / PW_128_DEN);
  localparam logic [9:0] PW_64_CYC     = 10'(OSC_HZ / PW_64_DEN);

  // oscillator cycles per second, default of the top parameter
  localparam int         SEC_DIV       = OSC_HZ;

  // byte access from the serial bus engine
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rtis_req_t;

  // countdown timer control, oscillator domain
  typedef struct packed {
    logic       load;
    logic [7:0] n;
    logic [1:0] src;
    logic       src_tick;
  } rtis_tmr_t;

endpackage

/* hw/rtis_core.sv */
/*
  Interrupt flags, interrupt output and seconds/integrity register of the
  real-time clock, with the countdown timer core in the oscillator domain.
  Assumes: register accesses arrive on clk from the bus engine; timer
  controls and source ticks arrive on osc_clk; supply and oscillator
  monitors are asynchronous levels; alarm_match is a clk-domain pulse.
*/
`timescale 1ns/1ps

module rtis_core #(
  parameter int SEC_DIV = rtis_pkg::SEC_DIV
) (
  // system clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // oscillator clock
  input  wire logic                osc_clk,
  // register access
  input  wire rtis_pkg::rtis_req_t req,
  output logic [7:0]               rdata,
  // event sources
  input  wire logic                alarm_match,
  input  wire logic                supply_low,
  input  wire logic                osc_stopped,
  input  wire rtis_pkg::rtis_tmr_t tmr,
  // interrupt pin, open drain
  output logic                     irq_level,
  output logic                     irq_oe
);

  // oscillator domain reset, released through two flops
  logic [1:0] osc_rst_sync_r;
  logic       osc_rst_n;

  always_ff @(posedge osc_clk) begin
    osc_rst_sync_r <= {osc_rst_sync_r[0], rst_n};
  end
  assign osc_rst_n = osc_rst_sync_r[1];

  // countdown timer, oscillator domain
  logic [7:0] tmr_cnt_r;
  logic [7:0] tmr_n_r;
  logic       tmr_expire;

  assign tmr_expire = tmr.src_tick && tmr_cnt_r == 8'h01;

  always_ff @(posedge osc_clk) begin
    if (!osc_rst_n) begin
      tmr_cnt_r <= 8'h00;
      tmr_n_r   <= 8'h00;
    end else if (tmr.load) begin
      tmr_cnt_r <= tmr.n;
      tmr_n_r   <= tmr.n;
    end else if (tmr_expire) begin
      tmr_cnt_r <= tmr_n_r;
    end else if (tmr.src_tick && tmr_cnt_r != 8'h00) begin
      tmr_cnt_r <= tmr_cnt_r - 8'h01;
    end
  end

  // interrupt pulse width in oscillator cycles
  logic [9:0] pw_len;

  always_comb begin
    pw_len = rtis_pkg::PW_64_CYC;
    if (tmr.src == rtis_pkg::SRC_4096HZ) begin
      pw_len = (tmr_n_r == 8'h01) ? rtis_pkg::PW_8192_CYC : rtis_pkg::PW_4096_CYC;
    end else if (tmr.src == rtis_pkg::SRC_64HZ && tmr_n_r == 8'h01) begin
      pw_len = rtis_pkg::PW_128_CYC;
    end
  end

  // pulse busy level; its rising edge doubles as the expiry event,
  // so the flag and the pulse start in one clk cycle
  logic       pw_busy_r;
  logic [9:0] pw_cnt_r;

  always_ff @(posedge osc_clk) begin
    if (!osc_rst_n) begin
      pw_busy_r <= 1'b0;
      pw_cnt_r  <= 10'h000;
    end else if (tmr_expire) begin
      pw_busy_r <= 1'b1;
      pw_cnt_r  <= pw_len - 10'h001;
    end else if (pw_cnt_r != 10'h000) begin
      pw_cnt_r  <= pw_cnt_r - 10'h001;
    end else begin
      pw_busy_r <= 1'b0;
    end
  end

  // one-second divider, reported as a toggle
  logic [15:0] sec_div_r;
  logic        sec_tgl_r;

  always_ff @(posedge osc_clk) begin
    if (!osc_rst_n) begin
      sec_div_r <= 16'h0000;
      sec_tgl_r <= 1'b0;
    end else if (sec_div_r == 16'(SEC_DIV - 1)) begin
      sec_div_r <= 16'h0000;
      sec_tgl_r <= ~sec_tgl_r;
    end else begin
      sec_div_r <= sec_div_r + 16'h0001;
    end
  end

  // crossings into clk: two flops; busy and seconds toggle get edge detection on later stages, the monitors stay levels
  logic [2:0] busy_sync_r;
  logic [2:0] sec_sync_r;
  logic [1:0] low_sync_r;
  logic [1:0] stop_sync_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_sync_r <= 3'h0;
      sec_sync_r  <= 3'h0;
      low_sync_r  <= 2'h0;
      stop_sync_r <= 2'h0;
    end else begin
      busy_sync_r <= {busy_sync_r[1:0], pw_busy_r};
      sec_sync_r  <= {sec_sync_r[1:0], sec_tgl_r};
      low_sync_r  <= {low_sync_r[0], supply_low};
      stop_sync_r <= {stop_sync_r[0], osc_stopped};
    end
  end

  logic pulse_lvl;
  logic cd_event;
  logic sec_tick;
  logic vl_event;

  assign pulse_lvl = busy_sync_r[1];
  assign cd_event  = busy_sync_r[1] && !busy_sync_r[2];
  assign sec_tick  = sec_sync_r[1] ^ sec_sync_r[2];
  assign vl_event  = low_sync_r[1] || stop_sync_r[1];

  // register write decode
  logic wr_ctrl;
  logic wr_secs;

  assign wr_ctrl = req.wr && req.addr == rtis_pkg::ADDR_CTRL;
  assign wr_secs = req.wr && req.addr == rtis_pkg::ADDR_SECS;

  // control bits; upper bits 7..5 are not stored and read zero
  logic mode_r;
  logic aie_r;
  logic tie_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_r <= rtis_pkg::CTRL_RESET[rtis_pkg::BIT_MODE];
      aie_r  <= rtis_pkg::CTRL_RESET[rtis_pkg::BIT_AIE];
      tie_r  <= rtis_pkg::CTRL_RESET[rtis_pkg::BIT_TIE];
    end else if (wr_ctrl) begin
      mode_r <= req.wdata[rtis_pkg::BIT_MODE];
      aie_r  <= req.wdata[rtis_pkg::BIT_AIE];
      tie_r  <= req.wdata[rtis_pkg::BIT_TIE];
    end
  end

  // flags: a write ANDs into the flag, a new event wins over the clear
  logic af_r;
  logic tf_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      af_r <= rtis_pkg::CTRL_RESET[rtis_pkg::BIT_AF];
      tf_r <= rtis_pkg::CTRL_RESET[rtis_pkg::BIT_TF];
    end else begin
      if (alarm_match) begin
        af_r <= 1'b1;
      end else if (wr_ctrl) begin
        af_r <= af_r & req.wdata[rtis_pkg::BIT_AF];
      end
      if (cd_event) begin
        tf_r <= 1'b1;
      end else if (wr_ctrl) begin
        tf_r <= tf_r & req.wdata[rtis_pkg::BIT_TF];
      end
    end
  end

  // integrity flag: set by monitors, cleared only by a host write
  logic vl_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vl_r <= rtis_pkg::VL_RESET;
    end else if (vl_event) begin
      vl_r <= 1'b1;
    end else if (wr_secs) begin
      vl_r <= req.wdata[rtis_pkg::BIT_VL];
    end
  end

  // BCD seconds; a host write beats a tick arriving in the same cycle
  logic [2:0] tens_r;
  logic [3:0] units_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tens_r  <= rtis_pkg::SECS_RESET[rtis_pkg::TENS_MSB:rtis_pkg::TENS_LSB];
      units_r <= rtis_pkg::SECS_RESET[rtis_pkg::UNITS_MSB:0];
    end else if (wr_secs) begin
      tens_r  <= req.wdata[rtis_pkg::TENS_MSB:rtis_pkg::TENS_LSB];
      units_r <= req.wdata[rtis_pkg::UNITS_MSB:0];
    end else if (sec_tick) begin
      if (units_r >= 4'h9) begin
        units_r <= 4'h0;
        tens_r  <= (tens_r >= 3'h5) ? 3'h0 : tens_r + 3'h1;
      end else begin
        units_r <= units_r + 4'h1;
      end
    end
  end

  // read data, registered
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (req.addr == rtis_pkg::ADDR_CTRL) begin
      rdata <= {3'h0, mode_r, af_r, tf_r, aie_r, tie_r};
    end else if (req.addr == rtis_pkg::ADDR_SECS) begin
      rdata <= {vl_r, tens_r, units_r};
    end else begin
      rdata <= 8'h00;
    end
  end

  // interrupt: level mode follows the flag, pulse mode follows the
  // pulse; an enabled alarm flag holds the pin in either mode
  logic cd_irq;

  assign cd_irq = mode_r ? pulse_lvl : tf_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_oe <= 1'b0;
    end else begin
      irq_oe <= (af_r && aie_r) || (cd_irq && tie_r);
    end
  end

  // open drain: the pin only ever pulls low; kept in a flop so that
  // every output of the block leaves a register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_level <= 1'b0;
    end else begin
      irq_level <= 1'b0;
    end
  end

  // checks
  sequence s_pulse_starts;
    cd_event && mode_r && tie_r;
  endsequence

  sequence s_pin_and_flag;
    ##2 irq_oe && tf_r;
  endsequence

  a_level_follow: assert property (@(posedge clk) disable iff (!rst_n)
    !mode_r && tf_r && tie_r && !wr_ctrl |=> irq_oe)
    else $error("level mode output not following countdown flag");

  a_pulse_start: assert property (@(posedge clk) disable iff (!rst_n)
    s_pulse_starts ##1 (mode_r && tie_r) |-> ##1 irq_oe && tf_r)
    else $error("pulse and flag did not start together");

  a_pulse_seq: assert property (@(posedge clk) disable iff (!rst_n)
    s_pulse_starts ##0 !wr_ctrl |-> s_pin_and_flag or ##1 !(mode_r && tie_r))
    else $error("enabled expiry gave no pulse");

  a_alarm_hold: assert property (@(posedge clk) disable iff (!rst_n)
    af_r && aie_r && !wr_ctrl |=> irq_oe)
    else $error("alarm flag with enable not holding output");

  a_gate_off: assert property (@(posedge clk) disable iff (!rst_n)
    !aie_r && !tie_r && !wr_ctrl |=> !irq_oe)
    else $error("output asserted with both enables off");

  a_af_clear: assert property (@(posedge clk) disable iff (!rst_n)
    wr_ctrl && !req.wdata[rtis_pkg::BIT_AF] && !alarm_match |=> !af_r)
    else $error("alarm flag not cleared by zero write");

  a_tf_clear: assert property (@(posedge clk) disable iff (!rst_n)
    wr_ctrl && !req.wdata[rtis_pkg::BIT_TF] && !cd_event |=> !tf_r)
    else $error("countdown flag not cleared by zero write");

  a_flag_and: assert property (@(posedge clk) disable iff (!rst_n)
    wr_ctrl && req.wdata[rtis_pkg::BIT_AF] && !alarm_match |=> af_r == $past(af_r))
    else $error("writing one changed the alarm flag");

  a_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
    alarm_match or cd_event |=> (af_r || !$past(alarm_match)) && (tf_r || !$past(cd_event)))
    else $error("event lost against a clear");

  a_reset_vals: assert property (@(posedge clk)
    !rst_n |=> !mode_r && !af_r && !tf_r && !aie_r && !tie_r && vl_r)
    else $error("control or integrity reset value wrong");

  a_vl_set: assert property (@(posedge clk) disable iff (!rst_n)
    vl_event |=> vl_r)
    else $error("integrity flag not set by monitor");

  a_bcd_range: assert property (@(posedge clk) disable iff (!rst_n)
    !$past(wr_secs) |-> tens_r <= 3'h5 && units_r <= 4'h9 || $past(tens_r > 3'h5 || units_r > 4'h9))
    else $error("seconds left BCD range");

  a_tmr_stop: assert property (@(posedge osc_clk) disable iff (!osc_rst_n)
    tmr_cnt_r == 8'h00 && !tmr.load |=> tmr_cnt_r == 8'h00)
    else $error("timer counted from zero");

  a_pw_4096: assert property (@(posedge osc_clk) disable iff (!osc_rst_n)
    tmr_expire && tmr.src == rtis_pkg::SRC_4096HZ && tmr_n_r == 8'h01 && !tmr.load
      |=> pw_busy_r [*4] ##1 !pw_busy_r || tmr_expire)
    else $error("short pulse width wrong");

  a_pw_64: assert property (@(posedge osc_clk) disable iff (!osc_rst_n)
    tmr_expire && tmr.src != rtis_pkg::SRC_4096HZ && tmr_n_r > 8'h01
      |=> pw_cnt_r == rtis_pkg::PW_64_CYC - 10'h001)
    else $error("long pulse width wrong");

endmodule

/* dv/rtis_host.sv */
/*
  Host model: issues byte writes and reads toward the register port.
  Assumes the device captures req on rising clk and registers rdata.
*/
`timescale 1ns/1ps
module rtis_host (
  // clock
  input  wire logic           clk,
  // register access
  output rtis_pkg::rtis_req_t req,
  input  wire logic [7:0]     rdata
);
  initial req = '0;

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, addr: a, wdata: (a == rtis_pkg::ADDR_CTRL) ? (d & 8'h1f) : d};
    @(posedge clk);
    req.wr    <= 1'b0;
    // stale data must not look valid
    req.wdata <= ~req.wdata;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    req.addr <= a;
    @(posedge clk);
    @(posedge clk);
    #1 d = rdata;
  endtask
endmodule

/* dv/tb.sv */
/*
  Self-checking bench for the interrupt, status and seconds logic.
  Assumes rtis_core and the host model; the pin has a pull-up here.
*/
`timescale 1ns/1ps
module tb;
  localparam int SDIV   = 16;
  localparam int PSRC[6] = '{0, 0, 1, 1, 2, 3};
  localparam int PN[6]   = '{1, 2, 1, 2, 1, 1};
  localparam int PW[6]   = '{4, 8, 256, 512, 512, 512};
  logic                clk         = 1'b0;
  logic                osc_clk     = 1'b0;
  logic                rst_n       = 1'b0;
  logic                alarm_match = 1'b0;
  logic                supply_low  = 1'b0;
  logic                osc_stopped = 1'b0;
  rtis_pkg::rtis_tmr_t tmr         = '0;
  rtis_pkg::rtis_req_t req;
  logic [7:0]          rdata;
  logic [7:0]          v;
  logic                irq_level;
  logic                irq_oe;
  wire                 irq_n;
  int                  fails           = 0;
  int                  samples_checked = 0;

  always #12.5 clk = ~clk;
  always #16 osc_clk = ~osc_clk;
  assign irq_n = irq_oe ? irq_level : 1'b1;

  rtis_host host (.clk(clk), .req(req), .rdata(rdata));
  rtis_core #(.SEC_DIV(SDIV)) dut (.clk(clk), .rst_n(rst_n), .osc_clk(osc_clk), .req(req), .rdata(rdata),
    .alarm_match(alarm_match), .supply_low(supply_low), .osc_stopped(osc_stopped), .tmr(tmr),
    .irq_level(irq_level), .irq_oe(irq_oe));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
    samples_checked++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, v);
    chk(v, exp);
  endtask

  task automatic clks(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic fire(input logic [7:0] n, input logic [1:0] src, input int ticks);
    @(posedge osc_clk) tmr <= '{load: 1'b1, n: n, src: src, src_tick: 1'b0};
    @(posedge osc_clk) tmr.load <= 1'b0;
    repeat (ticks) begin
      @(posedge osc_clk) tmr.src_tick <= 1'b1;
      @(posedge osc_clk) tmr.src_tick <= 1'b0;
    end
  endtask

  task automatic alarm();
    @(posedge clk) alarm_match <= 1'b1;
    @(posedge clk) alarm_match <= 1'b0;
  endtask

  task automatic t_reset();
    rdc(rtis_pkg::ADDR_CTRL, 8'h00);
    rdc(rtis_pkg::ADDR_SECS, 8'h80);
    host.wr(8'h05, 8'hff);
    rdc(8'h05, 8'h00);
    rdc(rtis_pkg::ADDR_CTRL, 8'h00);
    $display("t_reset done");
  endtask

  task automatic t_flags();
    host.wr(rtis_pkg::ADDR_CTRL, 8'h02);
    alarm();
    fire(8'h01, rtis_pkg::SRC_4096HZ, 1);
    clks(20);
    rdc(rtis_pkg::ADDR_CTRL, 8'h0e);
    chk({7'h0, irq_n}, 8'h00);
    host.wr(rtis_pkg::ADDR_CTRL, 8'h0a);
    rdc(rtis_pkg::ADDR_CTRL, 8'h0a);
    host.wr(rtis_pkg::ADDR_CTRL, 8'h06);
    rdc(rtis_pkg::ADDR_CTRL, 8'h02);
    chk({7'h0, irq_n}, 8'h01);
    host.wr(rtis_pkg::ADDR_CTRL, 8'h13);
    alarm();
    fire(8'h01, rtis_pkg::SRC_4096HZ, 1);
    clks(700);
    chk({7'h0, irq_n}, 8'h00);
    host.wr(rtis_pkg::ADDR_CTRL, 8'h00);
    $display("t_flags done");
  endtask

  task automatic t_level();
    host.wr(rtis_pkg::ADDR_CTRL, 8'h01);
    fire(8'h00, rtis_pkg::SRC_4096HZ, 3);
    clks(20);
    rdc(rtis_pkg::ADDR_CTRL, 8'h01);
    fire(8'h01, rtis_pkg::SRC_4096HZ, 1);
    clks(700);
    chk({7'h0, irq_n}, 8'h00);
    chk({7'h0, irq_level}, 8'h00);
    host.wr(rtis_pkg::ADDR_CTRL, 8'h01);
    rdc(rtis_pkg::ADDR_CTRL, 8'h01);
    chk({7'h0, irq_n}, 8'h01);
    $display("t_level done");
  endtask

  task automatic t_pulse();
    int c;
    int e;
    host.wr(rtis_pkg::ADDR_CTRL, 8'h11);
    for (int i = 0; i < 6; i++) begin
      e = PW[i] * 32 / 25;
      fire(8'(PN[i]), 2'(PSRC[i]), PN[i]);
      c = 0;
      while (irq_n !== 1'b0 && c < 400) begin
        clks(1);
        c++;
      end
      // rdata lags the flag by one cycle: clear when the pin falls, set one cycle on
      chk({7'h0, rdata[2]}, 8'h00);
      clks(1);
      chk({7'h0, rdata[2]}, 8'h01);
      c = 1;
      while (irq_n === 1'b0 && c < 2000) begin
        clks(1);
        c++;
      end
      chk_rng(16'(c), 16'(e - 3), 16'(e + 3));
      rdc(rtis_pkg::ADDR_CTRL, 8'h15);
      host.wr(rtis_pkg::ADDR_CTRL, 8'h11);
    end
    host.wr(rtis_pkg::ADDR_CTRL, 8'h00);
    $display("t_pulse done");
  endtask

  task automatic poll(input logic [7:0] old, input logic [7:0] exp);
    int c;
    c = 0;
    v = old;
    while (v === old && c < 60) begin
      host.rd(rtis_pkg::ADDR_SECS, v);
      c++;
    end
    chk(v, exp);
  endtask

  task automatic t_secs();
    host.wr(rtis_pkg::ADDR_SECS, 8'h59);
    poll(8'h59, 8'h00);
    host.wr(rtis_pkg::ADDR_SECS, 8'h09);
    poll(8'h09, 8'h10);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      if (k == 0) supply_low <= 1'b1;
      else osc_stopped <= 1'b1;
      clks(8);
      supply_low  <= 1'b0;
      osc_stopped <= 1'b0;
      clks(8);
      host.rd(rtis_pkg::ADDR_SECS, v);
      chk(v & 8'h80, 8'h80);
      host.wr(rtis_pkg::ADDR_SECS, 8'h00);
      host.rd(rtis_pkg::ADDR_SECS, v);
      chk(v & 8'h80, 8'h00);
    end
    $display("t_secs done");
  endtask

  task automatic end_of_test();
    $display("checked=%0d mismatches=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    // generous against roughly 4k cycles of expected traffic
    #2ms;
    fails++;
    end_of_test();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_flags();
    t_level();
    t_pulse();
    t_secs();
    end_of_test();
  end
endmodule
